// File: include/synth_pkg.sv
package synth_pkg;

	// Serial word and latch bank
	localparam int WORD_W = 32;
	localparam int SEL_W = 3;
	localparam int NUM_LATCH = 8;
	localparam logic [31:0] LATCH_RST = 32'h0000_0000;
	localparam logic [2:0] R0_IDX = 3'h0;
	localparam logic [2:0] R1_IDX = 3'h1;
	localparam logic [2:0] R2_IDX = 3'h2;
	localparam logic [2:0] R3_IDX = 3'h3;
	localparam logic [2:0] R5_IDX = 3'h5;

	// Latch 0 fields
	localparam int MUX_LSB = 27;
	localparam int MUX_W = 4;
	localparam int INT_LSB = 15;
	localparam int INT_W = 12;
	localparam int DIVIDE_NUMERATOR_MSB_LSB = 3;
	localparam int DIVIDE_NUMERATOR_MSB_W = 12;

	// Latch 1 fields (double buffered)
	localparam int DIVIDE_NUMERATOR_LSB_LSB = 15;
	localparam int DIVIDE_NUMERATOR_LSB_W = 13;

	// Latch 2 fields (double buffered)
	localparam int RCNT_LSB = 15;
	localparam int RCNT_W = 5;

	// Latch 3 mode bits
	localparam int OFFSET_OFF_BIT = 10;
	localparam int KEY_EN_BIT = 11;

	// Latch 5 keying deviation
	localparam int DEV_LSB = 3;
	localparam int DEV_W = 16;

	// Divider and modulator
	localparam int DIVIDE_NUMERATOR_W = 25;
	localparam logic [11:0] INT_MIN = 12'h017;
	localparam logic [11:0] INT_MAX = 12'hFFF;
	localparam logic [4:0] RCNT_MAX = 5'h1F;

	// Observation select codes
	localparam logic [3:0] OBS_LOW = 4'h0;
	localparam logic [3:0] OBS_HIGH = 4'h1;
	localparam logic [3:0] OBS_PFD = 4'h2;
	localparam logic [3:0] OBS_CARRY = 4'h3;
	localparam logic [3:0] OBS_KEY = 4'h4;
	localparam logic [3:0] OBS_VALID = 4'h5;
	localparam logic [3:0] OBS_ENABLE = 4'h6;

endpackage

// File: src/divide_numerator_accum.sv
module divide_numerator_accum #(
	parameter int DIVIDE_NUMERATOR_W = synth_pkg::DIVIDE_NUMERATOR_W
) (
	input wire logic clk_in, // System clock
	input wire logic rst_n_in, // Synchronised reset, active low
	input wire logic step_in, // Phase detector tick
	input wire logic [DIVIDE_NUMERATOR_W-1:0] divide_numerator_in, // Fraction numerator
	input wire logic half_lsb_in, // Adds the half-step offset
	output logic carry_out, // Carry of the latest step
	output logic [DIVIDE_NUMERATOR_W:0] acc_out // Accumulator in half-step units
);

	logic [DIVIDE_NUMERATOR_W:0] acc_r;
	logic [DIVIDE_NUMERATOR_W:0] acc_nxt;
	logic carry_r;
	logic carry_nxt;
	logic [DIVIDE_NUMERATOR_W+1:0] sum;

	// Modulus is 2^(DIVIDE_NUMERATOR_W+1) half steps; the extra half step is the fixed offset
	always_comb begin
		sum = {1'b0, acc_r} + {1'b0, divide_numerator_in, half_lsb_in}; // [RULE6] [RULE7]
		acc_nxt = acc_r;
		carry_nxt = carry_r;
		if (step_in) begin
			acc_nxt = sum[DIVIDE_NUMERATOR_W:0];
			carry_nxt = sum[DIVIDE_NUMERATOR_W+1];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_r <= '0;
			carry_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			carry_r <= carry_nxt;
		end
	end

	assign carry_out = carry_r;
	assign acc_out = acc_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_divide_numerator_step;
		step_in |=> {carry_r, acc_r} ==
			$past({1'b0, acc_r}) + $past({1'b0, divide_numerator_in, half_lsb_in});
	endproperty
	a_divide_numerator_step: assert property (p_divide_numerator_step) else $error("fraction step wrong"); // [RULE6]

	property p_half_offset;
		step_in && half_lsb_in && divide_numerator_in == '0 && !(&acc_r) |=> acc_r == $past(acc_r) + 1'b1;
	endproperty
	a_half_offset: assert property (p_half_offset) else $error("offset not added"); // [RULE7]

	property p_hold;
		!step_in |=> $stable(acc_r) && $stable(carry_r);
	endproperty
	a_hold: assert property (p_hold) else $error("accumulator moved without tick"); // [RULE6]

endmodule

// File: src/serial_shifter.sv
module serial_shifter #(
	parameter int WORD_W = synth_pkg::WORD_W
) (
	input wire logic clk_in, // System clock
	input wire logic rst_n_in, // Synchronised reset, active low
	input wire logic shift_in, // Serial clock rising edge pulse
	input wire logic data_in, // Sampled serial data
	output logic [WORD_W-1:0] word_out // Shift register contents
);

	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;

	// First bit in ends at the top, so the last three bits land in [2:0]
	always_comb begin
		shift_nxt = shift_r;
		if (shift_in) begin
			shift_nxt = {shift_r[WORD_W-2:0], data_in}; // [RULE1] [RULE2] [RULE14]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_r <= '0;
		end else begin
			shift_r <= shift_nxt;
		end
	end

	assign word_out = shift_r;

endmodule

// File: src/synth_serial_load_and_divider.sv
// Contract
// [RULE1] Sample serial data on serial clock rise
// [RULE2] Word arrives MSB first, select bits last
// [RULE3] Load strobe high copies word into one latch
// [RULE4] Chip enable low: power down, pump three-state
// [RULE5] Integer divide ratio valid from 23 to 4095
// [RULE6] Fraction modulus is two to the 25
// [RULE7] Modulator adds half-step offset unless disabled
// [RULE8] Power down opens series, closes shunt switch
// [RULE9] Keying symbol input steers keying and ramps; code only switches the deviation in one step, no ramp
// [RULE10] Observation pin shows a selectable internal signal
// [RULE11] 32-bit shifter; select 000..111 picks latch 0..7
// [RULE12] Buffered settings apply after next latch 0 write
// [RULE13] Select code sits in word bits 2..0
// [RULE14] Shifter keeps last 32 bits until loaded
module synth_serial_load_and_divider (
	input wire logic clk_in, // 100 MHz system clock
	input wire logic rst_n_in, // Asynchronous reset, active low
	input wire logic serial_clock_in, // Serial clock from host
	input wire logic serial_data_in, // Serial data from host
	input wire logic load_strobe_in, // Load strobe, active high
	input wire logic chip_enable_in, // Chip enable, low powers down
	input wire logic reference_input_pin_in, // Reference clock level
	input wire logic keying_symbol_input_in, // Keying symbol
	output logic observe_output_pin_out, // Multiplexed observation output
	output logic pump_oe_out, // Pump output drive enable
	output logic ref_series_switch_a_out, // Series switch A, high is closed
	output logic ref_series_switch_b_out, // Series switch B, high is closed
	output logic ref_shunt_switch_out, // Shunt switch, high is closed
	output logic power_down_out, // Device powered down
	output logic [12:0] feedback_ratio_out, // Integer plus modulator carry
	output logic ratio_valid_out, // Programmed integer within range
	output logic pfd_tick_out // Phase detector rate pulse
);

	localparam int W = synth_pkg::WORD_W;

	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Pin sampling; pins are synchronous to clk_in
	logic sclk_r;
	logic sclk_prev_r;
	logic sdata_r;
	logic load_r;
	logic ce_r;
	logic ref_r;
	logic ref_prev_r;
	logic key_r;
	logic sclk_rise;
	logic ref_rise;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_r <= 1'b0;
			sclk_prev_r <= 1'b0;
			sdata_r <= 1'b0;
			load_r <= 1'b0;
			ce_r <= 1'b0;
			ref_r <= 1'b0;
			ref_prev_r <= 1'b0;
			key_r <= 1'b0;
		end else begin
			sclk_r <= serial_clock_in;
			sclk_prev_r <= sclk_r;
			sdata_r <= serial_data_in;
			load_r <= load_strobe_in;
			ce_r <= chip_enable_in;
			ref_r <= reference_input_pin_in;
			ref_prev_r <= ref_r;
			key_r <= keying_symbol_input_in; // [RULE9]
		end
	end
	assign sclk_rise = sclk_r & ~sclk_prev_r; // [RULE1]
	assign ref_rise = ref_r & ~ref_prev_r;

	logic [W-1:0] shift_word;
	logic [2:0] sel;

	serial_shifter #(.WORD_W(W)) u_shifter (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.shift_in(sclk_rise),
		.data_in(sdata_r),
		.word_out(shift_word)
	);
	assign sel = shift_word[2:0]; // [RULE13]

	// Latch bank with double-buffered copies of latches 1 and 2
	logic [W-1:0] latch_r [synth_pkg::NUM_LATCH];
	logic [W-1:0] latch_nxt [synth_pkg::NUM_LATCH];
	logic [W-1:0] r1_act_r;
	logic [W-1:0] r1_act_nxt;
	logic [W-1:0] r2_act_r;
	logic [W-1:0] r2_act_nxt;

	always_comb begin
		latch_nxt = latch_r;
		r1_act_nxt = r1_act_r;
		r2_act_nxt = r2_act_r;
		if (load_r) begin
			latch_nxt[sel] = shift_word; // [RULE3] [RULE11] [RULE14]
			if (sel == synth_pkg::R0_IDX) begin
				r1_act_nxt = latch_r[synth_pkg::R1_IDX]; // [RULE12]
				r2_act_nxt = latch_r[synth_pkg::R2_IDX]; // [RULE12]
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < synth_pkg::NUM_LATCH; i++) begin
				latch_r[i] <= synth_pkg::LATCH_RST;
			end
			r1_act_r <= synth_pkg::LATCH_RST;
			r2_act_r <= synth_pkg::LATCH_RST;
		end else begin
			latch_r <= latch_nxt;
			r1_act_r <= r1_act_nxt;
			r2_act_r <= r2_act_nxt;
		end
	end

	// Field extraction
	logic [W-1:0] r0;
	logic [W-1:0] r3;
	logic [11:0] int_val;
	logic [3:0] mux_sel;
	logic [4:0] rcnt_field;
	logic [synth_pkg::DIVIDE_NUMERATOR_W-1:0] divide_numerator_base;
	logic [synth_pkg::DIVIDE_NUMERATOR_W-1:0] divide_numerator_eff;
	logic [synth_pkg::DEV_W-1:0] dev_val;
	logic offset_on;

	assign r0 = latch_r[synth_pkg::R0_IDX];
	assign r3 = latch_r[synth_pkg::R3_IDX];
	assign int_val = r0[synth_pkg::INT_LSB +: synth_pkg::INT_W];
	assign mux_sel = r0[synth_pkg::MUX_LSB +: synth_pkg::MUX_W];
	assign rcnt_field = r2_act_r[synth_pkg::RCNT_LSB +: synth_pkg::RCNT_W];
	assign divide_numerator_base = {r0[synth_pkg::DIVIDE_NUMERATOR_MSB_LSB +: synth_pkg::DIVIDE_NUMERATOR_MSB_W],
		r1_act_r[synth_pkg::DIVIDE_NUMERATOR_LSB_LSB +: synth_pkg::DIVIDE_NUMERATOR_LSB_W]};
	assign dev_val = latch_r[synth_pkg::R5_IDX][synth_pkg::DEV_LSB +: synth_pkg::DEV_W];
	assign offset_on = ~r3[synth_pkg::OFFSET_OFF_BIT]; // [RULE7]

	// Keyed deviation wraps within the fraction; it does not reach the integer
	always_comb begin
		divide_numerator_eff = divide_numerator_base;
		if (r3[synth_pkg::KEY_EN_BIT] && key_r) begin
			divide_numerator_eff = divide_numerator_base + {{(synth_pkg::DIVIDE_NUMERATOR_W - synth_pkg::DEV_W){1'b0}}, dev_val}; // [RULE9]
		end
	end

	// Reference counter: field 0 means divide by 32
	logic [4:0] rcnt_r;
	logic [4:0] rcnt_nxt;
	logic pfd_r;
	logic pfd_nxt;
	logic [4:0] rcnt_lim;

	always_comb begin
		rcnt_lim = (rcnt_field == 5'h00) ? synth_pkg::RCNT_MAX : rcnt_field - 5'h01;
		rcnt_nxt = rcnt_r;
		pfd_nxt = 1'b0;
		if (ce_r && ref_rise) begin
			if (rcnt_r >= rcnt_lim) begin
				rcnt_nxt = 5'h00;
				pfd_nxt = 1'b1;
			end else begin
				rcnt_nxt = rcnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rcnt_r <= 5'h00;
			pfd_r <= 1'b0;
		end else begin
			rcnt_r <= rcnt_nxt;
			pfd_r <= pfd_nxt;
		end
	end

	logic carry;

	divide_numerator_accum #(.DIVIDE_NUMERATOR_W(synth_pkg::DIVIDE_NUMERATOR_W)) u_divide_numerator (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.step_in(pfd_r),
		.divide_numerator_in(divide_numerator_eff),
		.half_lsb_in(offset_on),
		.carry_out(carry),
		.acc_out()
	);

	// Output group
	logic [12:0] ratio_r;
	logic [12:0] ratio_nxt;
	logic valid_r;
	logic valid_nxt;
	logic obs_r;
	logic obs_nxt;
	logic oe_r;
	logic oe_nxt;
	logic sw_ser_r;
	logic sw_ser_nxt;
	logic sw_sh_r;
	logic sw_sh_nxt;

	always_comb begin
		ratio_nxt = {1'b0, int_val} + {12'h000, carry};
		// Upper bound of 4095 is the full 12-bit field
		valid_nxt = (int_val >= synth_pkg::INT_MIN); // [RULE5]
		oe_nxt = ce_r; // [RULE4]
		sw_ser_nxt = ce_r; // [RULE8]
		sw_sh_nxt = ~ce_r; // [RULE8]
		case (mux_sel) // [RULE10]
			synth_pkg::OBS_HIGH: obs_nxt = 1'b1;
			synth_pkg::OBS_PFD: obs_nxt = pfd_r;
			synth_pkg::OBS_CARRY: obs_nxt = carry;
			synth_pkg::OBS_KEY: obs_nxt = key_r;
			synth_pkg::OBS_VALID: obs_nxt = valid_r;
			synth_pkg::OBS_ENABLE: obs_nxt = ce_r;
			default: obs_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ratio_r <= 13'h0000;
			valid_r <= 1'b0;
			obs_r <= 1'b0;
			oe_r <= 1'b0;
			sw_ser_r <= 1'b0;
			sw_sh_r <= 1'b1;
		end else begin
			ratio_r <= ratio_nxt;
			valid_r <= valid_nxt;
			obs_r <= obs_nxt;
			oe_r <= oe_nxt;
			sw_ser_r <= sw_ser_nxt;
			sw_sh_r <= sw_sh_nxt;
		end
	end

	assign observe_output_pin_out = obs_r;
	assign pump_oe_out = oe_r;
	assign ref_series_switch_a_out = sw_ser_r;
	assign ref_series_switch_b_out = sw_ser_r;
	assign ref_shunt_switch_out = sw_sh_r;
	assign power_down_out = sw_sh_r;
	assign feedback_ratio_out = ratio_r;
	assign ratio_valid_out = valid_r;
	assign pfd_tick_out = pfd_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	property p_shift_in;
		sclk_rise |=> shift_word == {$past(shift_word[W-2:0]), $past(sdata_r)};
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in"); // [RULE1]

	property p_shift_hold;
		!sclk_rise |=> $stable(shift_word);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shifter moved without clock"); // [RULE14]

	property p_load_five;
		load_r && shift_word[2:0] == 3'h5 |=> latch_r[5] == $past(shift_word);
	endproperty
	a_load_five: assert property (p_load_five) else $error("latch five not loaded"); // [RULE3]

	property p_load_only_one;
		!(load_r && sel == 3'h6) |=> $stable(latch_r[6]);
	endproperty
	a_load_only_one: assert property (p_load_only_one) else $error("wrong latch written"); // [RULE11]

	property p_pd_pump;
		!chip_enable_in |=> ##1 !pump_oe_out && power_down_out;
	endproperty
	a_pd_pump: assert property (p_pd_pump) else $error("pump not released in power down"); // [RULE4]

	property p_pd_switch;
		!chip_enable_in ##1 !chip_enable_in |=> ##1 !ref_series_switch_a_out &&
			!ref_series_switch_b_out && ref_shunt_switch_out;
	endproperty
	a_pd_switch: assert property (p_pd_switch) else $error("reference switches wrong"); // [RULE8]

	property p_ratio_low;
		load_r && sel == synth_pkg::R0_IDX &&
			shift_word[synth_pkg::INT_LSB +: synth_pkg::INT_W] < synth_pkg::INT_MIN
			|=> ##1 !ratio_valid_out;
	endproperty
	a_ratio_low: assert property (p_ratio_low) else $error("low ratio flagged valid"); // [RULE5]

	property p_dbuf_wait;
		load_r && sel == synth_pkg::R1_IDX |=> $stable(r1_act_r);
	endproperty
	a_dbuf_wait: assert property (p_dbuf_wait) else $error("buffered value applied early"); // [RULE12]

	property p_dbuf_apply;
		load_r && sel == synth_pkg::R0_IDX |=> r1_act_r == $past(latch_r[synth_pkg::R1_IDX]);
	endproperty
	a_dbuf_apply: assert property (p_dbuf_apply) else $error("buffered value not applied"); // [RULE12]

	property p_obs_key;
		mux_sel == synth_pkg::OBS_KEY |=> observe_output_pin_out == $past(key_r);
	endproperty
	a_obs_key: assert property (p_obs_key) else $error("observation pin wrong"); // [RULE10]

	c_load_r0: cover property (load_r && sel == synth_pkg::R0_IDX);
	c_power_down: cover property (ce_r ##1 !ce_r);
	c_carry: cover property (pfd_r ##1 carry);
	c_keyed: cover property (r3[synth_pkg::KEY_EN_BIT] && key_r && pfd_r);

endmodule

// File: verif/host_model.sv
module host_model (
	input wire logic clk_in, // System clock
	output logic sclk_out, // Serial clock to the device
	output logic sdata_out, // Serial data to the device
	output logic strobe_out // Load strobe to the device
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		strobe_out = 1'b0;
	end
	// Serial clock stands low between frames; data shows the inverse afterwards
	task automatic send(input logic [31:0] word, input logic load);
		@(posedge clk_in);
		for (int i = 31; i >= 0; i--) begin
			sdata_out <= word[i];
			repeat (3) @(posedge clk_in);
			sclk_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			sclk_out <= 1'b0;
		end
		sdata_out <= ~word[0];
		repeat (3) @(posedge clk_in);
		if (load) begin
			strobe_out <= 1'b1;
			repeat (2) @(posedge clk_in);
			strobe_out <= 1'b0;
		end
		repeat (3) @(posedge clk_in);
		// Return off the edge so that callers read settled outputs
		@(negedge clk_in);
	endtask
endmodule

// File: verif/tb_synth_serial_load_and_divider.sv
module tb_synth_serial_load_and_divider;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce = 1'b0;
	logic ref_in = 1'b0;
	logic key = 1'b0;
	logic sclk, sdata, strobe, obs, oe, swa, swb, shunt, pd, valid, tick;
	logic [12:0] ratio;
	int err_count = 0;
	int checked = 0;
	int rc = 0;
	int gap;

	always #5 clk_in = ~clk_in;
	// Reference rises every 6 cycles
	always @(posedge clk_in) begin
		rc <= (rc == 2) ? 0 : rc + 1;
		if (rc == 2) ref_in <= ~ref_in;
	end

	host_model HOST (.clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));
	synth_serial_load_and_divider DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_clock_in(sclk), .serial_data_in(sdata),
		.load_strobe_in(strobe), .chip_enable_in(ce), .reference_input_pin_in(ref_in),
		.keying_symbol_input_in(key), .observe_output_pin_out(obs), .pump_oe_out(oe),
		.ref_series_switch_a_out(swa), .ref_series_switch_b_out(swb),
		.ref_shunt_switch_out(shunt), .power_down_out(pd), .feedback_ratio_out(ratio),
		.ratio_valid_out(valid), .pfd_tick_out(tick));

	function automatic logic [31:0] w0(input logic [3:0] mux, input logic [11:0] n,
		input logic [11:0] fm);
		return {1'b0, mux, n, fm, 3'h0};
	endfunction

	task automatic check(input logic [12:0] got, input logic [12:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic wait_tick();
		int c;
		c = 0;
		do begin
			@(negedge clk_in);
			c++;
		end while (tick !== 1'b1 && c < 1000);
		if (c >= 1000) check(13'h0001, 13'h0000, "no tick");
	endtask

	task automatic tick_gap(output int n);
		wait_tick();
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (tick !== 1'b1 && n < 1000);
	endtask

	task automatic t_reset();
		@(negedge clk_in);
		check({oe, swa, swb, shunt, pd}, 13'h0003, "reset state");
	endtask

	task automatic t_power();
		int n;
		@(posedge clk_in);
		ce <= 1'b0;
		repeat (4) @(negedge clk_in);
		check({oe, swa, swb, shunt, pd}, 13'h0003, "power down pins");
		n = 0;
		repeat (400) begin
			@(negedge clk_in);
			if (tick === 1'b1) n++;
		end
		check(n, 0, "tick in power down");
		@(posedge clk_in);
		ce <= 1'b1;
		repeat (4) @(negedge clk_in);
		check({oe, swa, swb, shunt, pd}, 13'h001C, "power up pins");
	endtask

	task automatic t_range();
		logic [11:0] ns[4] = '{12'h0016, 12'h0017, 12'h0FFF, 12'h0000};
		logic v;
		foreach (ns[i]) begin
			v = (ns[i] >= 12'h0017);
			HOST.send(w0(4'h5, ns[i], 12'h000), 1'b1);
			check(valid, v, "ratio valid");
			check(ratio, {1'b0, ns[i]}, "ratio value");
			check(obs, v, "observe valid");
		end
	endtask

	task automatic t_select();
		HOST.send(w0(4'h0, 12'h0017, 12'h000), 1'b1);
		for (int k = 1; k < 8; k++) begin
			HOST.send(32'h3000_0000 | k, 1'b1);
			check(obs, 13'h0000, "wrong latch hit");
			check(ratio, 13'h0017, "ratio moved");
		end
		HOST.send(w0(4'h6, 12'h0017, 12'h000), 1'b1);
		check(obs, 13'h0001, "latch zero select");
	endtask

	task automatic t_shift();
		HOST.send(w0(4'h1, 12'h0064, 12'h000), 1'b0);
		check(ratio, 13'h0017, "load without strobe");
		HOST.send(w0(4'h0, 12'h00C8, 12'h000), 1'b1);
		check(ratio, 13'h00C8, "last word kept");
		check(obs, 13'h0000, "old bits leaked");
	endtask

	task automatic t_modes();
		logic [3:0] cd[6] = '{4'h0, 4'h1, 4'h4, 4'h4, 4'h6, 4'h7};
		logic kv[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		logic ex[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		foreach (cd[i]) begin
			@(posedge clk_in);
			key <= kv[i];
			HOST.send(w0(cd[i], 12'h0032, 12'h000), 1'b1);
			check(obs, ex[i], "observe select");
		end
	endtask

	task automatic t_dbuf();
		HOST.send(32'h0001_0002, 1'b1);
		tick_gap(gap);
		tick_gap(gap);
		check(gap, 192, "divider applied early");
		HOST.send(w0(4'h0, 12'h0032, 12'h000), 1'b1);
		tick_gap(gap);
		tick_gap(gap);
		check(gap, 12, "divider not applied");
	endtask

	// Counts, over 20 ticks, the steps whose ratio carries above the integer 0x32
	task automatic carries(output int n);
		n = 0;
		repeat (20) begin
			wait_tick();
			repeat (2) @(negedge clk_in);
			if (ratio === 13'h0033) n++;
		end
	endtask

	task automatic t_divide_numerator();
		int n;
		HOST.send(w0(4'h0, 12'h0032, 12'h800), 1'b1);
		carries(n);
		check(n >= 9 && n <= 11, 13'h0001, "half fraction carry rate");
	endtask

	// Fraction just below full scale carries almost every tick; the keyed
	// deviation wraps it to a small value that almost never carries
	task automatic t_key();
		int n;
		HOST.send(32'h0007_FFFD, 1'b1);
		HOST.send(32'h0000_0C03, 1'b1);
		@(posedge clk_in);
		key <= 1'b0;
		HOST.send(w0(4'h3, 12'h0032, 12'hFFF), 1'b1);
		carries(n);
		check(n >= 19, 13'h0001, "unkeyed carry rate");
		check(obs, 13'h0001, "observe carry");
		@(posedge clk_in);
		key <= 1'b1;
		carries(n);
		check(n <= 2, 13'h0001, "keyed carry rate");
		HOST.send(w0(4'h2, 12'h0032, 12'h000), 1'b1);
		n = 0;
		repeat (120) begin
			@(negedge clk_in);
			if (obs === 1'b1) n++;
		end
		check(n, 10, "observe tick count");
	endtask

	task automatic wrap_up();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#400000;
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		t_reset();
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		ce <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_range();
		t_select();
		t_shift();
		t_modes();
		t_dbuf();
		t_divide_numerator();
		t_key();
		t_power();
		wrap_up();
	end
endmodule
